//--- common/lcd_pkg.sv
package lcd_pkg;

  typedef enum logic [1:0] {ACC_IDLE, ACC_WRITE, ACC_READ, ACC_CATCH}
    acc_state_t;

  typedef struct packed {
    logic [1:0] com_idx;
    logic invert;
    logic frame_start;
  } frame_pos_t;

  typedef struct packed {
    logic [3:0] com_en;
    logic [3:0] com_act;
    logic [28:0] seg_en;
    logic [28:0] seg_on;
    logic invert;
    logic bias;
  } lcd_pins_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] div;
    logic [1:0] last;
    frame_pos_t pos;
  } timer_state_t;

  typedef struct packed {
    logic [63:0][7:0] mem;
    logic [7:0] rdata;
  } mem_state_t;

endpackage

//--- common/lcd_seg_params.svh
`ifndef LCD_SEG_PARAMS_SVH
`define LCD_SEG_PARAMS_SVH

// Register addresses on the special function register port
`define ADDR_CONFIG 8'h95
`define ADDR_CLOCK 8'h96
`define ADDR_SEG_EN_A 8'h97
`define ADDR_PTR 8'hAC
`define ADDR_DATA 8'hAE
`define ADDR_CONFIG2 8'hB1
`define ADDR_SEG_EN_B 8'hED

// Reset values
`define RST_REG 8'h00
`define TIMER_DIV_RESET 8'h40
`define TIMER_LAST_RESET 2'h3

// display_config_reg fields
`define CFG_MUX_LSB 0
`define CFG_BIAS_BIT 2
`define CFG_CLOCK_SELECT_BIT_BIT 3
`define CFG_BLINK_ENABLE_BIT_BIT 5
`define CFG_MEMCLR_BIT 6

// display_clock_reg fields
`define CLK_FD_LSB 0
`define CLK_BLINK_FREQUENCY_FIELD_LSB 4
`define CLK_BLINK_MODE_FIELD_LSB 6

// segment_memory_pointer fields
`define PTR_ADDR_LSB 0
`define PTR_SCREEN_LSB 4
`define PTR_WRITE_BIT 7
`define PTR_WMASK 8'hBF

// display_config_second_reg fields
`define CY_REFRESH_BIT 0
`define CY_UPDONE_BIT 1
`define CY_SCREEN_LSB 2
`define CY_WMASK 8'hCD

// Segment enable masks
`define SEG_EN_A_MASK 8'hFC
`define SEG_EN_B_MASK 8'h0F

// Multiplex codes and blink modes
`define MUX_3X 2'h2
`define MUX_4X 2'h3
`define BLK_SW_OFF 2'h0
`define BLK_SW_ON 2'h1
`define BLK_AUTO 2'h2

// Memory geometry
`define MEM_LAST_BYTE 4'hE
`define MEM_HOLE 4'hF

// Blink timing, counted in ticks of the 128 Hz clock
`define DISPLAY_CLOCK_REG_SLOW_HZ 128
`define BLINK_AUTO_HZ 2
`define BLINK_HALF_AUTO_TICKS (`DISPLAY_CLOCK_REG_SLOW_HZ / (2 * `BLINK_AUTO_HZ))
`define BLINK_HALF_1HZ_TICKS (`DISPLAY_CLOCK_REG_SLOW_HZ / 2)

`endif

//--- logic/lcd_frame_timer.sv
`include "lcd_seg_params.svh"

module lcd_frame_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Selected LCD clock tick and settings
  input wire logic tick_i,
  input wire logic slow_i,
  input wire logic [1:0] mux_i,
  input wire logic [3:0] fd_i,
  // Frame position
  output lcd_pkg::frame_pos_t pos_o
);

  lcd_pkg::timer_state_t s_r;
  lcd_pkg::timer_state_t s_nxt;
  logic [7:0] half;

  // LCD clock ticks per common-line step
  function automatic logic [7:0] step_div(input logic slow,
                                          input logic [1:0] mux,
                                          input logic [3:0] fd);
    logic two_way;
    logic [7:0] n;
    two_way = ~mux[1];
    n = (fd == 4'h0) ? 8'h20 : {4'h0, fd} + 8'h01;
    if (!slow) begin
      if (two_way) begin
        step_div = n << 2;
      end else if (mux == `MUX_3X && fd == 4'h1) begin
        step_div = 8'h06;
      end else begin
        step_div = n << 1;
      end
    end else if (fd == 4'hF) begin
      step_div = 8'h01;
    end else if (fd == 4'h0) begin
      step_div = 8'h02;
    end else if (!two_way || fd == 4'h1) begin
      step_div = 8'h04;
    end else if (fd == 4'h2) begin
      step_div = 8'h06;
    end else begin
      step_div = 8'h08;
    end
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.pos.frame_start = 1'b0;
    half = s_r.div >> 1;
    if (tick_i) begin
      if (s_r.cnt == s_r.div - 8'h01) begin
        s_nxt.cnt = 8'h00;
        s_nxt.pos.invert = ~s_r.pos.invert;
        if (s_r.pos.com_idx == s_r.last) begin
          s_nxt.pos.com_idx = 2'h0;
          s_nxt.pos.frame_start = 1'b1;
          // New settings only at a frame boundary
          s_nxt.div = step_div(slow_i, mux_i, fd_i);
          s_nxt.last = mux_i[1] ? {1'b1, mux_i[0]} : 2'h1;
        end else begin
          s_nxt.pos.com_idx = s_r.pos.com_idx + 2'h1;
        end
      end else begin
        s_nxt.cnt = s_r.cnt + 8'h01;
        // A one-tick step cannot hold a mid-step inversion
        if (half != 8'h00 && s_r.cnt == half - 8'h01) begin
          s_nxt.pos.invert = ~s_r.pos.invert;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '{cnt: 8'h00, div: `TIMER_DIV_RESET,
               last: `TIMER_LAST_RESET, pos: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pos_o = s_r.pos;

endmodule

//--- logic/lcd_seg_mem.sv
`include "lcd_seg_params.svh"

module lcd_seg_mem (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Access port
  input wire logic clr_i,
  input wire logic we_i,
  input wire logic [5:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);

  lcd_pkg::mem_state_t s_r;
  lcd_pkg::mem_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = s_r.mem[addr_i];
    // Byte 15 of each screen does not exist
    if (we_i && addr_i[3:0] != `MEM_HOLE) begin
      s_nxt.mem[addr_i] = wdata_i;
    end
    if (clr_i) begin
      s_nxt.mem = '0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o = s_r.rdata;

endmodule

//--- logic/lcd_segment_driver.sv

`include "lcd_seg_params.svh"

module lcd_segment_driver (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Special function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // LCD clock sources, one-cycle ticks
  input wire logic clk2048_tick_i,
  input wire logic clk128_tick_i,
  // Glass side
  output lcd_pkg::lcd_pins_t pins_o,
  output logic display_on_o
);

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] clk;
    logic [7:0] sega;
    logic [7:0] segb;
    logic [7:0] ptr;
    logic [7:0] dat;
    logic [7:0] cy;
    logic [7:0] rdata;
    lcd_pkg::acc_state_t acc;
    logic memclr;
    logic scan_on;
    logic [3:0] scan_idx;
    logic [1:0] scan_screen;
    logic scan_rd;
    logic [3:0] scan_rd_idx;
    logic [14:0][7:0] image;
    logic [8:0] blink_cnt;
    logic blink_ph;
    lcd_pkg::lcd_pins_t pins;
  } drv_state_t;

  drv_state_t s_r;
  drv_state_t s_nxt;

  logic mem_clr;
  logic mem_we;
  logic [5:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic lcd_tick;
  lcd_pkg::frame_pos_t pos;
  logic [1:0] mux;
  logic [1:0] blk_mode;
  logic [1:0] blk_freq;
  logic disp_on;
  logic scan_issue;
  logic [28:0] seg_en;
  logic [8:0] blink_half;

  assign mux = s_r.cfg[`CFG_MUX_LSB +: 2];
  assign blk_mode = s_r.clk[`CLK_BLINK_MODE_FIELD_LSB +: 2];
  assign blk_freq = s_r.clk[`CLK_BLINK_FREQUENCY_FIELD_LSB +: 2];
  assign lcd_tick = s_r.cfg[`CFG_CLOCK_SELECT_BIT_BIT] ? clk128_tick_i
                                             : clk2048_tick_i;

  // Half period of the automatic blink in 128 Hz ticks
  function automatic logic [8:0] blink_half_ticks(input logic [1:0] mode,
                                                  input logic [1:0] freq);
    logic [8:0] one_hz;
    one_hz = 9'(`BLINK_HALF_1HZ_TICKS);
    if (mode == `BLK_AUTO) begin
      blink_half_ticks = 9'(`BLINK_HALF_AUTO_TICKS);
    end else begin
      blink_half_ticks = 9'(one_hz * ({7'h00, freq} + 9'h001));
    end
  endfunction

  lcd_frame_timer u_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .tick_i(lcd_tick),
    .slow_i(s_r.cfg[`CFG_CLOCK_SELECT_BIT_BIT]),
    .mux_i(mux),
    .fd_i(s_r.clk[`CLK_FD_LSB +: 4]),
    .pos_o(pos)
  );

  lcd_seg_mem u_mem (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .clr_i(mem_clr),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  // Pin roles
  always_comb begin
    seg_en = '0;
    seg_en[15:0] = '1;
    seg_en[19:16] = s_r.segb[3:0];
    seg_en[25:20] = s_r.sega[7:2];
    seg_en[27] = (mux != `MUX_4X);
    seg_en[28] = ~mux[1];
  end

  // Display on/off under blinking
  always_comb begin
    blink_half = blink_half_ticks(blk_mode, blk_freq);
    if (!s_r.cfg[`CFG_BLINK_ENABLE_BIT_BIT]) begin
      disp_on = 1'b1;
    end else begin
      case (blk_mode)
        `BLK_SW_OFF: disp_on = 1'b0;
        `BLK_SW_ON: disp_on = 1'b1;
        default: disp_on = s_r.blink_ph;
      endcase
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.memclr = 1'b0;
    mem_clr = s_r.memclr;
    mem_we = 1'b0;
    mem_addr = {s_r.ptr[`PTR_SCREEN_LSB +: 2], s_r.ptr[`PTR_ADDR_LSB +: 4]};
    mem_wdata = s_r.dat;
    scan_issue = 1'b0;

    // Pointer-started access; the port belongs to it while busy
    case (s_r.acc)
      lcd_pkg::ACC_WRITE: begin
        mem_we = 1'b1;
        s_nxt.acc = lcd_pkg::ACC_IDLE;
      end
      lcd_pkg::ACC_READ: begin
        s_nxt.acc = lcd_pkg::ACC_CATCH;
      end
      lcd_pkg::ACC_CATCH: begin
        s_nxt.dat = mem_rdata;
        s_nxt.acc = lcd_pkg::ACC_IDLE;
        scan_issue = s_r.scan_on;
      end
      default: begin
        scan_issue = s_r.scan_on;
      end
    endcase

    // Image reload steals only idle port cycles
    s_nxt.scan_rd = scan_issue;
    s_nxt.scan_rd_idx = s_r.scan_idx;
    if (scan_issue) begin
      mem_addr = {s_r.scan_screen, s_r.scan_idx};
      s_nxt.scan_idx = s_r.scan_idx + 4'h1;
      if (s_r.scan_idx == `MEM_LAST_BYTE) begin
        s_nxt.scan_on = 1'b0;
      end
    end
    if (s_r.scan_rd) begin
      s_nxt.image[s_r.scan_rd_idx] = mem_rdata;
    end

    // Register writes
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        `ADDR_CONFIG: begin
          s_nxt.cfg = sfr_wdata_i;
          s_nxt.cfg[`CFG_MEMCLR_BIT] = 1'b0;
          s_nxt.memclr = sfr_wdata_i[`CFG_MEMCLR_BIT];
        end
        `ADDR_CLOCK: begin
          s_nxt.clk = sfr_wdata_i;
        end
        `ADDR_SEG_EN_A: begin
          // Reserved low bits are held at zero
          s_nxt.sega = sfr_wdata_i & `SEG_EN_A_MASK;
        end
        `ADDR_SEG_EN_B: begin
          s_nxt.segb = sfr_wdata_i & `SEG_EN_B_MASK;
        end
        `ADDR_PTR: begin
          s_nxt.ptr = sfr_wdata_i & `PTR_WMASK;
          if (sfr_wdata_i[`PTR_WRITE_BIT]) begin
            s_nxt.acc = lcd_pkg::ACC_WRITE;
          end else begin
            s_nxt.acc = lcd_pkg::ACC_READ;
          end
        end
        `ADDR_DATA: begin
          s_nxt.dat = sfr_wdata_i;
        end
        `ADDR_CONFIG2: begin
          s_nxt.cy = sfr_wdata_i & `CY_WMASK;
          // Starting a hold clears the update-finished flag
          s_nxt.cy[`CY_UPDONE_BIT] = s_r.cy[`CY_UPDONE_BIT] &
                                     ~sfr_wdata_i[`CY_REFRESH_BIT];
        end
        default: begin
        end
      endcase
    end

    // Frame start: reload image unless held; the set wins over a clear
    if (pos.frame_start && !s_r.cy[`CY_REFRESH_BIT]) begin
      s_nxt.scan_on = 1'b1;
      s_nxt.scan_idx = 4'h0;
      s_nxt.scan_screen = s_r.cy[`CY_SCREEN_LSB +: 2];
      s_nxt.cy[`CY_UPDONE_BIT] = 1'b1;
    end

    // Automatic blink phase, timed on the 128 Hz tick
    if (clk128_tick_i) begin
      if (s_r.blink_cnt >= blink_half - 9'h001) begin
        s_nxt.blink_cnt = 9'h000;
        s_nxt.blink_ph = ~s_r.blink_ph;
      end else begin
        s_nxt.blink_cnt = s_r.blink_cnt + 9'h001;
      end
    end

    // Register reads answer one cycle later
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        `ADDR_CONFIG: s_nxt.rdata = s_r.cfg;
        `ADDR_CLOCK: s_nxt.rdata = s_r.clk;
        `ADDR_SEG_EN_A: s_nxt.rdata = s_r.sega;
        `ADDR_SEG_EN_B: s_nxt.rdata = s_r.segb;
        `ADDR_PTR: s_nxt.rdata = s_r.ptr;
        `ADDR_DATA: s_nxt.rdata = s_r.dat;
        `ADDR_CONFIG2: s_nxt.rdata = s_r.cy;
        default: s_nxt.rdata = 8'h00;
      endcase
    end

    // Glass drive
    s_nxt.pins.seg_en = seg_en;
    s_nxt.pins.com_en = {mux == `MUX_4X, mux[1], 2'b11};
    s_nxt.pins.com_act = (4'h1 << pos.com_idx) & s_nxt.pins.com_en;
    s_nxt.pins.invert = pos.invert;
    s_nxt.pins.bias = s_r.cfg[`CFG_BIAS_BIT];
    for (int k = 0; k < 29; k++) begin
      s_nxt.pins.seg_on[k] = seg_en[k] & disp_on &
        s_r.image[k / 2][(k % 2) * 4 + int'(pos.com_idx)];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '{cfg: `RST_REG, clk: `RST_REG, sega: `RST_REG,
               segb: `RST_REG, ptr: `RST_REG, dat: `RST_REG,
               cy: `RST_REG, rdata: 8'h00, acc: lcd_pkg::ACC_IDLE,
               memclr: 1'b0, scan_on: 1'b0, scan_idx: 4'h0,
               scan_screen: 2'h0, scan_rd: 1'b0, scan_rd_idx: 4'h0,
               image: '0, blink_cnt: 9'h000, blink_ph: 1'b0,
               pins: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sfr_rdata_o = s_r.rdata;
  assign pins_o = s_r.pins;
  assign display_on_o = disp_on;

endmodule

//--- verif/lcd_glass_model.sv
module lcd_glass_model (
  // Clock and drive lines
  input wire logic clk_i,
  input wire lcd_pkg::lcd_pins_t pins_i,
  // Image each common line last saw
  output logic [3:0][28:0] img_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // An idle common keeps its last view, as the glass holds charge
  always @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (pins_i.com_act[i] && pins_i.com_en[i]) img_o[i] <= pins_i.seg_on;
    end
  end
endmodule

//--- verif/lcd_segment_driver_monitor.sv
`include "lcd_seg_params.svh"

module lcd_segment_driver_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  // Ticks and glass side
  input wire logic clk2048_tick_i,
  input wire logic clk128_tick_i,
  input wire lcd_pkg::lcd_pins_t pins_o,
  input wire logic display_on_o
);
  logic up_r;
  logic [5:0] ena_r;
  logic [3:0] com_r;
  logic inv_r;
  logic [1:0] tog_r;
  logic [2:0] tog_now;
  logic stepped;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Toggles of this step, the one landing on the step edge included
  assign tog_now = {1'b0, tog_r} + {2'h0, pins_o.invert != inv_r};
  // A common masked to zero by a mux change is not a real step
  assign stepped = pins_o.com_act != com_r && com_r != 4'h0 &&
    pins_o.com_act != 4'h0;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      up_r <= 1'b0;
      ena_r <= 6'h00;
      com_r <= 4'h0;
      inv_r <= 1'b0;
      tog_r <= 2'h0;
    end else begin
      up_r <= 1'b1;
      if (sfr_wr_i && sfr_addr_i == `ADDR_SEG_EN_A) begin
        ena_r <= sfr_wdata_i[7:2];
      end
      com_r <= pins_o.com_act;
      inv_r <= pins_o.invert;
      if (pins_o.com_act != com_r) begin
        tog_r <= 2'h0;
      end else begin
        tog_r <= (tog_now > 3'h2) ? 2'h3 : tog_now[1:0];
      end
    end
  end

  property p_low_segs;
    up_r |-> pins_o.seg_en[15:0] == 16'hFFFF && !pins_o.seg_en[26];
  endproperty
  a_low_segs: assert property (p_low_segs) else $error("low segs off");

  property p_shared_a;
    sfr_wr_i && sfr_addr_i == `ADDR_SEG_EN_A |=> ##1
      pins_o.seg_en[25:20] == ena_r;
  endproperty
  a_shared_a: assert property (p_shared_a) else $error("enable a lost");

  property p_com_map;
    up_r |-> pins_o.com_en[1:0] == 2'h3 &&
      pins_o.com_en[2] == !pins_o.seg_en[28] &&
      pins_o.com_en[3] == !pins_o.seg_en[27] &&
      (!pins_o.com_en[3] || pins_o.com_en[2]);
  endproperty
  a_com_map: assert property (p_com_map) else $error("dual pin wrong");

  property p_com_one;
    up_r |-> $onehot0(pins_o.com_act) &&
      (pins_o.com_act & ~pins_o.com_en) == 4'h0;
  endproperty
  a_com_one: assert property (p_com_one) else $error("common not one");

  property p_inv_rate;
    stepped |-> tog_now inside {3'h1, 3'h2};
  endproperty
  a_inv_rate: assert property (p_inv_rate) else $error("invert rate");

  property p_blank;
    !display_on_o |=> pins_o.seg_on == 29'h0;
  endproperty
  a_blank: assert property (p_blank) else $error("dark not blank");

  property p_on_sub;
    (pins_o.seg_on & ~pins_o.seg_en) == 29'h0;
  endproperty
  a_on_sub: assert property (p_on_sub) else $error("io pin lit");

  property p_rd_hold;
    !sfr_rd_i |=> $stable(sfr_rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");

  property p_clr_read;
    sfr_rd_i && sfr_addr_i == `ADDR_CONFIG |=>
      !sfr_rdata_o[`CFG_MEMCLR_BIT];
  endproperty
  a_clr_read: assert property (p_clr_read) else $error("clear stuck");

  c_step: cover property (stepped);
  c_dark: cover property (!display_on_o);
  c_read: cover property (sfr_rd_i ##1 sfr_rdata_o != 8'h00);
endmodule

bind lcd_segment_driver lcd_segment_driver_monitor i_mon (
  .clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
  .sfr_rdata_o(sfr_rdata_o), .clk2048_tick_i(clk2048_tick_i),
  .clk128_tick_i(clk128_tick_i), .pins_o(pins_o),
  .display_on_o(display_on_o)
);

//--- verif/tb_lcd_segment_driver.sv
`include "lcd_seg_params.svh"

module tb_lcd_segment_driver;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdata;
  logic t2k = 1'b0;
  logic t128 = 1'b0;
  lcd_pkg::lcd_pins_t pins;
  logic dsp;
  logic [3:0][28:0] img;
  logic [7:0] q;
  logic [2:0] tc = 3'h0;
  logic [7:0] regs [8] = '{8'h95, 8'h96, 8'h97, 8'hAC, 8'hAE, 8'hB1,
    8'hED, 8'h00};
  int seed = 20;
  int bad_count = 0;
  int check_count = 0;

  always #2 clk = ~clk;
  // Fast ticks: 2048 source every 2 cycles, 128 source every 8
  always @(negedge clk) begin
    tc <= tc + 3'h1;
    t2k <= tc[0];
    t128 <= &tc;
  end

  lcd_segment_driver i_dut (
    .clk_i(clk), .nrst_i(nrst), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdata),
    .clk2048_tick_i(t2k), .clk128_tick_i(t128), .pins_o(pins),
    .display_on_o(dsp)
  );
  lcd_glass_model i_glass (.clk_i(clk), .pins_i(pins), .img_o(img));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = w;
    rd = !w;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    q = rdata;
  endtask

  // The extra cycle keeps the next access off the pending memory cycle
  task automatic macc(input logic w, input logic [1:0] s,
                      input logic [3:0] a, input logic [7:0] d);
    if (w) acc(1'b1, `ADDR_DATA, d);
    acc(1'b1, `ADDR_PTR, {w, 1'b0, s, a});
    @(negedge clk);
    if (!w) acc(1'b0, `ADDR_DATA, 8'h00);
  endtask

  function automatic logic [3:0] obs(input bit s);
    return s ? {3'h0, dsp} : pins.com_act;
  endfunction

  task automatic wchg(input bit s, output int n);
    logic [3:0] c;
    c = obs(s);
    n = 0;
    while (obs(s) === c && n < 9000) begin
      @(negedge clk);
      n++;
    end
  endtask

  function automatic int exp_d(logic cs, logic [3:0] fd, logic [1:0] m);
    int n;
    n = (fd == 4'h0) ? 32 : fd + 1;
    if (!cs) return m[1] ? ((m == 2'h2 && fd == 4'h1) ? 6 : 2 * n) : 4 * n;
    if (fd == 4'hF) return 1;
    if (fd == 4'h0) return 2;
    if (m[1] || fd == 4'h1) return 4;
    return (fd == 4'h2) ? 6 : 8;
  endfunction

  initial begin
    int n;
    logic cs;
    logic [3:0] fd;
    logic [1:0] m;
    logic [7:0] b;
    repeat (5) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    foreach (regs[i]) begin
      acc(1'b0, regs[i], 8'h00);
      chk(q, 0);
    end
    chk(pins.seg_en, 29'h1800FFFF);
    chk(pins.seg_on, 0);
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      b = (i == 0) ? 8'hFC : (i == 1) ? 8'hA8 : 8'($random(seed)) & 8'hFC;
      acc(1'b1, `ADDR_SEG_EN_A, b);
      acc(1'b1, `ADDR_SEG_EN_B, ~b);
      acc(1'b0, `ADDR_SEG_EN_A, 8'h00);
      chk(q, b & `SEG_EN_A_MASK);
      acc(1'b0, `ADDR_SEG_EN_B, 8'h00);
      chk(q, ~b & `SEG_EN_B_MASK);
      chk(pins.seg_en[25:16], {b[7:2], ~b[3:0]});
    end
    $display("enable test done");
    for (int i = 0; i < 9; i++) begin
      {cs, fd, m} = (i == 0) ? 7'h06 : (i == 1) ? 7'h7D : (i == 2) ? 7'h00
        : (i == 3) ? 7'h43 : 7'($random(seed));
      acc(1'b1, `ADDR_CLOCK, {4'h0, fd});
      acc(1'b1, `ADDR_CONFIG, {4'h0, cs, fd[0], m});
      repeat (7) wchg(1'b0, n);
      wchg(1'b0, n);
      chk(n, exp_d(cs, fd, m) * (cs ? 8 : 2));
      chk({pins.com_en, pins.seg_en[28:27], pins.bias},
        {m == 2'h3, m[1], 2'h3, !m[1], m != 2'h3, fd[0]});
    end
    $display("timing test done");
    acc(1'b1, `ADDR_CONFIG, 8'h28);
    for (int k = 0; k < 7; k++) begin
      b = (k < 3) ? {k[1:0], 6'h00} : {2'h3, 2'(k - 3), 4'h0};
      acc(1'b1, `ADDR_CLOCK, b);
      if (k < 2) begin
        chk(dsp, k[0]);
      end else begin
        wchg(1'b1, n);
        wchg(1'b1, n);
        chk(n, ((k == 2) ? 32 : 64 * (k - 2)) * 8);
      end
    end
    $display("blink test done");
    acc(1'b1, `ADDR_CONFIG2, 8'h09);
    acc(1'b1, `ADDR_CLOCK, 8'h0F);
    acc(1'b1, `ADDR_CONFIG, 8'h0B);
    b = 8'($random(seed));
    macc(1'b1, 2'h2, 4'h0, b);
    repeat (12) wchg(1'b0, n);
    chk(img[0][1:0], 2'h0);
    acc(1'b1, `ADDR_CONFIG2, 8'h08);
    repeat (12) wchg(1'b0, n);
    for (int i = 0; i < 4; i++) begin
      chk({img[i][1], img[i][0]}, {b[4 + i], b[i]});
    end
    $display("screen test done");
    for (int i = 0; i < 20; i++) begin
      {m, fd} = (i == 0) ? 6'h0F : 6'($random(seed));
      b = 8'($random(seed));
      macc(1'b1, m, fd, b);
      macc(1'b0, m, fd, 8'h00);
      chk(q, (fd == 4'hF) ? 8'h00 : b);
    end
    acc(1'b1, `ADDR_CONFIG, 8'h4B);
    acc(1'b0, `ADDR_CONFIG, 8'h00);
    chk(q, 8'h0B);
    for (int i = 0; i < 64; i += 7) begin
      macc(1'b0, 2'(i / 16), 4'(i), 8'h00);
      chk(q, 8'h00);
    end
    $display("memory test done");
    conclude();
  end

  initial begin
    #300000;
    bad_count++;
    conclude();
  end
endmodule
